// ---- core/rrs_exec.v ----
// execution unit for return, rotate and sleep instructions with an axi4-lite port
// Operation
// - interrupt exit loads pc from stack top and sets global interrupt enable
// - rotate left through carry: carry into bit 0, bit 7 into carry
// - rotate right through carry: carry into bit 7, bit 0 into carry
// - file address 0..127; destination 0 writes accumulator, 1 writes file
// - literal exit loads 8-bit literal into accumulator and pc from stack top
// - literal exit takes two instruction cycles
// - subroutine exit pops stack into pc, status flags unchanged
// - subroutine exit takes two instruction cycles
// - sleep clears watchdog counter and its prescaler
// - sleep clears the power-down flag
// - sleep sets the time-out flag
// - after sleep the core halts, no further instructions until wake-up
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rrs_defines.vh"
module rrs_exec
(
   // clock and reset
   input  wire        CLK,
   input  wire        RESET,
   // axi4-lite write address
   input  wire [7:0]  AWADDR,
   input  wire        AWVALID,
   output wire        AWREADY,
   // axi4-lite write data
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output wire        WREADY,
   // axi4-lite write response
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   // axi4-lite read address
   input  wire [7:0]  ARADDR,
   input  wire        ARVALID,
   output wire        ARREADY,
   // axi4-lite read data
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   // watchdog and sleep state
   output reg  [7:0]  WATCHDOG_COUNTER,
   output reg  [7:0]  WATCHDOG_PRESCALER,
   output reg         SLEEPING
);

   localparam ST_IDLE   = 2'h0;
   localparam ST_FLUSH  = 2'h1;
   localparam ST_SLEEP  = 2'h2;

   reg  [1:0]  state;
   reg  [7:0]  acc;
   reg  [7:0]  status;
   reg  [12:0] pc;
   reg  [6:0]  file_addr;
   reg  [7:0]  file_mem [0:127];
   reg  [12:0] stack [0:`RRS_STACK_DEPTH-1];
   reg  [2:0]  sp;
   reg  [1:0]  cyc;

   reg         aw_held;
   reg  [7:0]  aw_addr;
   reg         w_held;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   wire        do_write = aw_held && w_held && !BVALID;
   wire [3:0]  cmd_op   = w_data[`RRS_CMD_OP_LSB+3:`RRS_CMD_OP_LSB];
   wire        cmd_dest = w_data[`RRS_CMD_DEST_BIT];
   wire [6:0]  cmd_addr = w_data[`RRS_CMD_ADDR_MSB:0];
   wire [7:0]  cmd_lit  = w_data[7:0];
   wire [7:0]  file_val = file_mem[cmd_addr];
   wire        carry    = status[`RRS_ST_CARRY];
   wire [12:0] stack_top_entry      = stack[sp - 3'h1];
   // a command is accepted only while the core runs and no return is flushing
   wire        can_exec = (state == ST_IDLE);
   wire        is_cmd   = do_write && (aw_addr == `RRS_ADDR_CMD) && w_strb[1] && can_exec;

   assign AWREADY = !aw_held;
   assign WREADY  = !w_held;
   assign ARREADY = !RVALID;

   // rotate results
   wire [7:0]  rot_left  = {file_val[6:0], carry};
   wire [7:0]  rot_right = {carry, file_val[7:1]};

   reg  [7:0]  rot_res;
   reg         rot_carry;
   always @*
   begin
      if (cmd_op == `RRS_OP_ROT_LEFT)
      begin
         rot_res   = rot_left;
         rot_carry = file_val[7];
      end
      else
      begin
         rot_res   = rot_right;
         rot_carry = file_val[0];
      end
   end

   // write channel capture; address and data may arrive in either order
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held  <= 1'b0;
         w_data  <= 32'h0;
         w_strb  <= 4'h0;
         BVALID  <= 1'b0;
         BRESP   <= 2'h0;
      end
      else
      begin
         if (AWVALID && !aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && !w_held)
         begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            BVALID  <= 1'b1;
            case (aw_addr)
               `RRS_ADDR_CMD, `RRS_ADDR_ACC, `RRS_ADDR_STATUS, `RRS_ADDR_PC,
               `RRS_ADDR_FILE, `RRS_ADDR_STACK, `RRS_ADDR_WAKE: BRESP <= 2'h0;
               default: BRESP <= 2'h2;
            endcase
         end
         else if (BVALID && BREADY)
            BVALID <= 1'b0;
      end
   end

   // core state: instructions, sleep, and direct register loads
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         state              <= ST_IDLE;
         acc                <= 8'h00;
         status             <= `RRS_STATUS_RESET;
         pc                 <= 13'h0;
         sp                 <= 3'h0;
         cyc                <= 2'h0;
         file_addr          <= 7'h0;
         WATCHDOG_COUNTER   <= `RRS_WDT_RESET;
         WATCHDOG_PRESCALER <= `RRS_PRESC_RESET;
         SLEEPING           <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (WATCHDOG_PRESCALER == 8'hFF)
                  WATCHDOG_COUNTER <= WATCHDOG_COUNTER + 8'h01;
               WATCHDOG_PRESCALER <= WATCHDOG_PRESCALER + 8'h01;
               if (is_cmd)
               begin
                  pc <= pc + 13'h1;
                  case (cmd_op)
                     `RRS_OP_IRQ_EXIT:
                     begin
                        pc                 <= stack_top_entry;
                        sp                 <= sp - 3'h1;
                        status[`RRS_ST_GIE] <= 1'b1;
                        cyc                <= `RRS_RETURN_CYCLES - 2'h1;
                        state              <= ST_FLUSH;
                     end
                     `RRS_OP_LIT_EXIT:
                     begin
                        acc   <= cmd_lit;
                        pc    <= stack_top_entry;
                        sp    <= sp - 3'h1;
                        cyc   <= `RRS_RETURN_CYCLES - 2'h1;
                        state <= ST_FLUSH;
                     end
                     `RRS_OP_SUB_EXIT:
                     begin
                        pc    <= stack_top_entry;
                        sp    <= sp - 3'h1;
                        cyc   <= `RRS_RETURN_CYCLES - 2'h1;
                        state <= ST_FLUSH;
                     end
                     `RRS_OP_ROT_LEFT, `RRS_OP_ROT_RIGHT:
                     begin
                        status[`RRS_ST_CARRY] <= rot_carry;
                        file_addr             <= cmd_addr;
                        if (!cmd_dest)
                           acc <= rot_res;
                     end
                     `RRS_OP_SLEEP:
                     begin
                        WATCHDOG_COUNTER         <= 8'h00;
                        WATCHDOG_PRESCALER       <= 8'h00;
                        status[`RRS_ST_POWERDOWN] <= 1'b0;
                        status[`RRS_ST_TIMEOUT]   <= 1'b1;
                        SLEEPING                 <= 1'b1;
                        state                    <= ST_SLEEP;
                     end
                     default:
                        pc <= pc + 13'h1;
                  endcase
               end
               else if (do_write && w_strb[0] && aw_addr == `RRS_ADDR_ACC)
                  acc <= w_data[7:0];
               else if (do_write && w_strb[0] && aw_addr == `RRS_ADDR_STATUS)
                  status <= w_data[7:0];
               else if (do_write && aw_addr == `RRS_ADDR_PC)
                  pc <= w_data[12:0];
               else if (do_write && aw_addr == `RRS_ADDR_STACK)
                  sp <= sp + 3'h1;
            end
            ST_FLUSH:
            begin
               // second cycle discards the prefetched word
               cyc <= cyc - 2'h1;
               if (cyc == 2'h1)
                  state <= ST_IDLE;
            end
            ST_SLEEP:
            begin
               // oscillator stopped: the watchdog holds and commands are ignored
               if (do_write && aw_addr == `RRS_ADDR_WAKE && w_data[0])
               begin
                  SLEEPING <= 1'b0;
                  state    <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // file memory and stack storage, no reset needed for data
   always @(posedge CLK)
   begin
      if (is_cmd && cmd_dest &&
          (cmd_op == `RRS_OP_ROT_LEFT || cmd_op == `RRS_OP_ROT_RIGHT))
         file_mem[cmd_addr] <= rot_res;
      else if (do_write && w_strb[0] && aw_addr == `RRS_ADDR_FILE && can_exec)
         file_mem[w_data[14:8]] <= w_data[7:0];
      if (do_write && aw_addr == `RRS_ADDR_STACK && can_exec)
         stack[sp] <= w_data[12:0];
   end

   // read channel
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0;
         RRESP  <= 2'h0;
      end
      else if (ARVALID && !RVALID)
      begin
         RVALID <= 1'b1;
         RRESP  <= 2'h0;
         case (ARADDR)
            `RRS_ADDR_CMD:    RDATA <= 32'h0;
            `RRS_ADDR_ACC:    RDATA <= {24'h0, acc};
            `RRS_ADDR_STATUS: RDATA <= {22'h0, SLEEPING, (state == ST_FLUSH), status};
            `RRS_ADDR_PC:     RDATA <= {19'h0, pc};
            `RRS_ADDR_FILE:   RDATA <= {17'h0, file_addr, file_mem[file_addr]};
            `RRS_ADDR_STACK:  RDATA <= {16'h0, 1'b0, sp, stack_top_entry[11:0]} | {19'h0, stack_top_entry[12], 12'h0};
            `RRS_ADDR_WAKE:   RDATA <= {31'h0, SLEEPING};
            default:
            begin
               RDATA <= 32'h0;
               RRESP <= 2'h2;
            end
         endcase
      end
      else if (RVALID && RREADY)
         RVALID <= 1'b0;
   end

endmodule

// ---- inc/rrs_defines.vh ----
// constants for the return, rotate and sleep execution block
`ifndef RRS_DEFINES_VH
`define RRS_DEFINES_VH
// axi4-lite byte addresses
`define RRS_ADDR_CMD      8'h00
`define RRS_ADDR_ACC      8'h04
`define RRS_ADDR_STATUS   8'h08
`define RRS_ADDR_PC       8'h0C
`define RRS_ADDR_FILE     8'h10
`define RRS_ADDR_STACK    8'h14
`define RRS_ADDR_WAKE     8'h18
// command word fields
`define RRS_CMD_OP_LSB    12
`define RRS_CMD_DEST_BIT  7
`define RRS_CMD_ADDR_MSB  6
// opcodes in the command word
`define RRS_OP_NONE       4'h0
`define RRS_OP_IRQ_EXIT   4'h1
`define RRS_OP_ROT_LEFT   4'h2
`define RRS_OP_LIT_EXIT   4'h3
`define RRS_OP_ROT_RIGHT  4'h4
`define RRS_OP_SUB_EXIT   4'h5
`define RRS_OP_SLEEP      4'h6
// status register bit positions
`define RRS_ST_CARRY      0
`define RRS_ST_POWERDOWN  3
`define RRS_ST_TIMEOUT    4
`define RRS_ST_GIE        7
`define RRS_ST_BUSY       8
`define RRS_ST_SLEEP      9
// reset values
`define RRS_STATUS_RESET  8'h18
`define RRS_WDT_RESET     8'h00
`define RRS_PRESC_RESET   8'h00
// cycles taken by return instructions, and stack depth
`define RRS_RETURN_CYCLES 2'h2
`define RRS_STACK_DEPTH   8
`endif

// ---- tb/rrs_exec_properties.sv ----
// port checker for the return, rotate and sleep execution block
`timescale 1ns/1ps
module rrs_exec_properties
(
   // clock and reset
   input wire        CLK,
   input wire        RESET,
   // bus handshakes
   input wire        AWVALID,
   input wire        AWREADY,
   input wire        WVALID,
   input wire        WREADY,
   input wire [1:0]  BRESP,
   input wire        BVALID,
   input wire        BREADY,
   input wire        ARVALID,
   input wire        ARREADY,
   input wire [31:0] RDATA,
   input wire        RVALID,
   input wire        RREADY,
   // watchdog and sleep
   input wire [7:0]  WATCHDOG_COUNTER,
   input wire [7:0]  WATCHDOG_PRESCALER,
   input wire        SLEEPING
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   chk_wdt_cleared: assert property ($rose(SLEEPING) |->
      WATCHDOG_COUNTER == 8'h00 && WATCHDOG_PRESCALER == 8'h00) else $error("watchdog kept");
   chk_sleep_frozen: assert property (SLEEPING && $past(SLEEPING) |->
      $stable(WATCHDOG_COUNTER) && $stable(WATCHDOG_PRESCALER)) else $error("watchdog moved");
   chk_b_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   chk_r_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   chk_r_drop: assert property (RVALID && RREADY |=> !RVALID) else $error("read answer repeated");
   chk_r_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("no read answer");
   chk_b_answer: assert property (AWVALID && AWREADY && WVALID && WREADY && !BVALID
      |-> ##[1:2] BVALID) else $error("no write answer");
   chk_b_drop: assert property (BVALID && BREADY |=> !BVALID) else $error("response repeated");
   cover property ($rose(SLEEPING));
   cover property ($fell(SLEEPING));
   cover property (BVALID && BREADY && BRESP == 2'h2);
endmodule
bind rrs_exec rrs_exec_properties chk
(
   .CLK, .RESET, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
   .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
   .WATCHDOG_COUNTER, .WATCHDOG_PRESCALER, .SLEEPING
);

// ---- tb/tb.sv ----
// self-checking bench for the return, rotate and sleep execution block
`timescale 1ns/1ps
`include "rrs_defines.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb;
   reg         CLK = 1'b0;
   reg         RESET = 1'b1;
   reg  [7:0]  AWADDR = 8'h00;
   reg         AWVALID = 1'b0;
   reg  [31:0] WDATA = 32'h0;
   reg         WVALID = 1'b0;
   reg         BREADY = 1'b0;
   reg  [7:0]  ARADDR = 8'h00;
   reg         ARVALID = 1'b0;
   reg         RREADY = 1'b0;
   wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, SLEEPING;
   wire [1:0]  BRESP, RRESP;
   wire [31:0] RDATA;
   wire [7:0]  WATCHDOG_COUNTER, WATCHDOG_PRESCALER;
   integer     errors = 0;
   integer     cmp_count = 0;
   integer     cycles = 0;
   always #20 CLK = ~CLK;
   rrs_exec dut
   (
      .CLK, .RESET, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hF), .WVALID, .WREADY,
      .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
      .RREADY, .WATCHDOG_COUNTER, .WATCHDOG_PRESCALER, .SLEEPING
   );
   task tally_and_finish;
   begin
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // generous ceiling: the whole sequence needs under two hundred cycles
   always @(posedge CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   function [31:0] cmd(input [3:0] op, input [7:0] low);
      cmd = {16'h0000, op, 4'h0, low};
   endfunction
   task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
      reg aw;
      reg w;
   begin
      aw = 1'b0;
      w = 1'b0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge CLK);
         if (AWVALID && AWREADY)
         begin
            aw = 1'b1;
            AWVALID <= 1'b0;
         end
         if (WVALID && WREADY)
         begin
            w = 1'b1;
            WVALID <= 1'b0;
         end
      end
      while (!BVALID) @(posedge CLK);
      BREADY <= 1'b1;
      @(posedge CLK);
      `CHK("write response", r, BRESP)
      BREADY <= 1'b0;
   end
   endtask
   task automatic rd(input [7:0] a, input [31:0] e, input [1:0] r, input string n);
   begin
      ARADDR <= a;
      ARVALID <= 1'b1;
      @(posedge CLK);
      while (!ARREADY) @(posedge CLK);
      ARVALID <= 1'b0;
      while (!RVALID) @(posedge CLK);
      RREADY <= 1'b1;
      @(posedge CLK);
      `CHK(n, e, RDATA)
      `CHK("read response", r, RRESP)
      RREADY <= 1'b0;
   end
   endtask
   // a status read lands in the flush cycle after a return (lag 2) or just after it (lag 3)
   task automatic ret_busy(input [3:0] op, input integer lag, input [31:0] e);
   begin
      wr(`RRS_ADDR_STACK, 32'h0321, 2'h0);
      fork
         wr(`RRS_ADDR_CMD, cmd(op, 8'hFF), 2'h0);
         begin
            repeat (lag) @(posedge CLK);
            rd(`RRS_ADDR_STATUS, e, 2'h0, "busy");
         end
      join
   end
   endtask
   // every return holds the core busy for exactly one extra cycle
   task t_flush;
   begin
      ret_busy(`RRS_OP_LIT_EXIT, 2, 32'h198);
      ret_busy(`RRS_OP_LIT_EXIT, 3, 32'h098);
      ret_busy(`RRS_OP_SUB_EXIT, 2, 32'h198);
      ret_busy(`RRS_OP_SUB_EXIT, 3, 32'h098);
      ret_busy(`RRS_OP_IRQ_EXIT, 2, 32'h198);
      ret_busy(`RRS_OP_IRQ_EXIT, 3, 32'h098);
   end
   endtask
   // edge cases: top file address, carry both ways, both destinations
   task t_rotate;
   begin
      wr(`RRS_ADDR_FILE, 32'h7F81, 2'h0);
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_ROT_LEFT, 8'hFF), 2'h0);
      rd(`RRS_ADDR_FILE, 32'h7F02, 2'h0, "file");
      rd(`RRS_ADDR_STATUS, 32'h19, 2'h0, "status");
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_ROT_RIGHT, 8'h7F), 2'h0);
      rd(`RRS_ADDR_ACC, 32'h81, 2'h0, "acc");
      rd(`RRS_ADDR_FILE, 32'h7F02, 2'h0, "file");
      rd(`RRS_ADDR_STATUS, 32'h18, 2'h0, "status");
   end
   endtask
   task t_returns;
   begin
      wr(`RRS_ADDR_STACK, 32'h0ABC, 2'h0);
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_LIT_EXIT, 8'hFF), 2'h0);
      rd(`RRS_ADDR_ACC, 32'hFF, 2'h0, "acc");
      rd(`RRS_ADDR_PC, 32'h0ABC, 2'h0, "pc");
      rd(`RRS_ADDR_STATUS, 32'h18, 2'h0, "status");
      wr(`RRS_ADDR_STACK, 32'h0123, 2'h0);
      wr(`RRS_ADDR_STACK, 32'h0456, 2'h0);
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_SUB_EXIT, 8'h00), 2'h0);
      rd(`RRS_ADDR_PC, 32'h0456, 2'h0, "pc");
      rd(`RRS_ADDR_STACK, 32'h1123, 2'h0, "stack");
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_IRQ_EXIT, 8'h00), 2'h0);
      rd(`RRS_ADDR_PC, 32'h0123, 2'h0, "pc");
      rd(`RRS_ADDR_STATUS, 32'h98, 2'h0, "status");
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_NONE, 8'h00), 2'h0);
      rd(`RRS_ADDR_PC, 32'h0124, 2'h0, "pc");
   end
   endtask
   // a rotate sent while asleep must leave the accumulator alone
   task t_sleep;
   begin
      // time-out flag cleared first so that sleep has something to set
      wr(`RRS_ADDR_STATUS, 32'h88, 2'h0);
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_SLEEP, 8'h00), 2'h0);
      `CHK("sleeping", 1'b1, SLEEPING)
      `CHK("watchdog", 8'h00, WATCHDOG_COUNTER)
      `CHK("prescaler", 8'h00, WATCHDOG_PRESCALER)
      rd(`RRS_ADDR_STATUS, 32'h290, 2'h0, "status");
      wr(`RRS_ADDR_CMD, cmd(`RRS_OP_ROT_LEFT, 8'h7F), 2'h0);
      rd(`RRS_ADDR_ACC, 32'hFF, 2'h0, "acc");
      `CHK("prescaler", 8'h00, WATCHDOG_PRESCALER)
      wr(`RRS_ADDR_WAKE, 32'h1, 2'h0);
      `CHK("sleeping", 1'b0, SLEEPING)
      rd(`RRS_ADDR_STATUS, 32'h90, 2'h0, "status");
      wr(8'h1C, 32'h1, 2'h2);
      rd(8'h1C, 32'h0, 2'h2, "unmapped");
   end
   endtask
   initial
   begin
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      rd(`RRS_ADDR_STATUS, 32'h18, 2'h0, "status");
      t_rotate;
      t_returns;
      t_flush;
      t_sleep;
      tally_and_finish;
   end
endmodule
